// File: verilog/sca_pkg.sv
// Package for the segment code/peripheral attribute register bank.
// Assumes a plain register port with 16-bit addresses and 32-bit data.
package sca_pkg;

  // Address space split into equal segments, top bits select one
  localparam int          SEG_COUNT       = 16;
  localparam int          SEG_MSB         = 31;
  localparam int          SEG_LSB         = 28;
  localparam int          SEG_SIZE_MB     = 256;

  // Register addresses on the plain port, as printed
  localparam logic [15:0] CODE_MAP_ADDR   = 16'h8104;
  localparam logic [15:0] PERIPH_MAP_ADDR = 16'h810B;
  localparam logic [15:0] PCFG_B_ADDR     = 16'h9204;
  localparam logic [15:0] PCFG_C_ADDR     = 16'h9208;
  localparam logic [15:0] PCFG_A_ADDR     = 16'h920C;

  // Bit positions of the hard-wired segments
  localparam int          SEG_F_BIT       = 15;
  localparam int          SEG_C_BIT       = 12;

  // Implementation choice: peripheral designators 14..0 writable
  localparam bit          PERIPH_WRITABLE = 1'b1;

  // Writable masks and fixed values of the low halfwords
  localparam logic [15:0] CODE_WR_MASK    = 16'h6FFF;
  localparam logic [15:0] CODE_FIXED      = 16'h0000;
  localparam logic [15:0] PERIPH_WR_MASK  =
    PERIPH_WRITABLE ? 16'h7FFF : 16'h0000;
  localparam logic [15:0] PERIPH_FIXED    = 16'h8000;

  // Values after reset
  localparam logic [15:0] CODE_RESET      = 16'h0300;
  localparam logic [15:0] PERIPH_RESET    = 16'hC000;
  localparam logic [31:0] PCFG_RESET      = 32'h0000_0000;
  localparam logic [31:0] RD_IDLE         = 32'h0000_0000;

endpackage : sca_pkg

// File: verilog/sca_attr_if.sv
// Interface carrying the segment attribute maps to the fetch checker.
// Assumes one clock shared by both ends.
`timescale 1ns/10ps
interface sca_attr_if;
  logic [15:0] codeMap;    // Code cacheability bits, fixed bits applied
  logic [15:0] periphMap;  // Peripheral designators, fixed bits applied

  modport src (output codeMap, output periphMap);
  modport chk (input codeMap, input periphMap);
endinterface : sca_attr_if

// File: verilog/sca_fetch_check.sv
// Fetch attribute check: cacheability and peripheral trap per fetch.
// Assumes fetch requests come from logic on the same clock.
`timescale 1ns/10ps
module sca_fetch_check
  import sca_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  sca_attr_if.chk          attr,
  input  wire logic        fetchValid,
  input  wire logic [31:0] fetchAddr,
  output logic             fetchDone_r,
  output logic             fetchCacheable_r,
  output logic             fetchTrap_r
);

  // Segment index from the top address bits
  function automatic logic [3:0] segOf(input logic [31:0] a);
    segOf = a[SEG_MSB:SEG_LSB];
  endfunction : segOf

  wire logic [3:0] fetchSeg  = segOf(fetchAddr);
  wire logic       segPeriph = attr.periphMap[fetchSeg];
  // Peripheral wins over the cacheability bit
  wire logic       segCache  = attr.codeMap[fetchSeg] & ~segPeriph;

  // Registered fetch verdict, one cycle after the request
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fetchDone_r      <= 1'b0;
      fetchCacheable_r <= 1'b0;
      fetchTrap_r      <= 1'b0;
    end else begin
      fetchDone_r      <= fetchValid;
      fetchCacheable_r <= fetchValid & segCache;
      fetchTrap_r      <= fetchValid & segPeriph;
    end
  end

  // Peripheral segment fetch traps and is not cached
  AST_FETCH_TRAP: assert property (
    @(posedge clk) disable iff (sys_rst)
    fetchValid && attr.periphMap[segOf(fetchAddr)]
      |=> fetchTrap_r && !fetchCacheable_r)
    else $error("peripheral fetch not trapped");

  // Cacheable only when allowed and not peripheral
  AST_FETCH_CACHE: assert property (
    @(posedge clk) disable iff (sys_rst)
    fetchValid |=> fetchCacheable_r ==
      ($past(attr.codeMap[segOf(fetchAddr)])
       && !$past(attr.periphMap[segOf(fetchAddr)])))
    else $error("fetch cacheability wrong");

  // Segment F always traps, whatever the maps hold
  AST_FETCH_SEG_F: assert property (
    @(posedge clk) disable iff (sys_rst)
    fetchValid && fetchAddr[31:28] == 4'hF |=> fetchTrap_r)
    else $error("segment F fetch not trapped");

  // No verdict without a fetch
  AST_IDLE_QUIET: assert property (
    @(posedge clk) disable iff (sys_rst)
    !fetchValid |=> !fetchDone_r && !fetchTrap_r && !fetchCacheable_r)
    else $error("verdict without fetch");

  COV_FETCH_TRAP: cover property (@(posedge clk) disable iff (sys_rst)
    fetchTrap_r);
  COV_FETCH_CACHED: cover property (@(posedge clk) disable iff (sys_rst)
    fetchCacheable_r);

endmodule : sca_fetch_check

// File: verilog/sca_attr_regs.sv
// Segment attribute register bank: code cacheability, peripheral
// designators and three program memory configuration words.
// Assumes a core-side register port on clk and an init-lock level
// from core logic on the same clock.
`timescale 1ns/10ps

module sca_attr_regs
  import sca_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [15:0] regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic      [31:0] regRdData_r,
  output logic             wrRefused_r,
  input  wire logic        initLockOpen,
  input  wire logic        fetchValid,
  input  wire logic [31:0] fetchAddr,
  output logic             fetchDone_r,
  output logic             fetchCacheable_r,
  output logic             fetchTrap_r,
  output logic      [15:0] codeCacheAllow_r,
  output logic      [15:0] uncachedSeg_r,
  output logic      [31:0] progCfgA_r,
  output logic      [31:0] progCfgB_r,
  output logic      [31:0] progCfgC_r
);

  // Stored halfwords and configuration words
  logic [15:0] codeStore_r;
  logic [15:0] periphStore_r;
  logic [31:0] pcfgA_r;
  logic [31:0] pcfgB_r;
  logic [31:0] pcfgC_r;

  // Merge a write into a halfword under a writable mask
  function automatic logic [15:0] mergeBits(input logic [15:0] old,
                                            input logic [15:0] wr,
                                            input logic [15:0] msk);
    mergeBits = (old & ~msk) | (wr & msk);
  endfunction : mergeBits

  // Address decode
  wire logic hitCode   = (regAddr == CODE_MAP_ADDR);
  wire logic hitPeriph = (regAddr == PERIPH_MAP_ADDR);
  wire logic hitCfgA   = (regAddr == PCFG_A_ADDR);
  wire logic hitCfgB   = (regAddr == PCFG_B_ADDR);
  wire logic hitCfgC   = (regAddr == PCFG_C_ADDR);
  wire logic hitAny    = hitCode | hitPeriph | hitCfgA | hitCfgB | hitCfgC;

  // Writes only pass while the init lock stands open
  wire logic wrOpen    = regWrStb & initLockOpen;
  wire logic wrLocked  = regWrStb & ~initLockOpen & hitAny;

  // Visible values: fixed bits forced, stored ones masked
  wire logic [15:0] codeView   =
    (codeStore_r & CODE_WR_MASK) | CODE_FIXED;
  wire logic [15:0] periphView =
    (periphStore_r & PERIPH_WR_MASK) | PERIPH_FIXED;

  // Next values of the stored halfwords
  wire logic [15:0] codeStore_nxt   = (wrOpen & hitCode) ?
    mergeBits(codeStore_r, regWrData[15:0], CODE_WR_MASK) :
    codeStore_r;
  wire logic [15:0] periphStore_nxt = (wrOpen & hitPeriph) ?
    mergeBits(periphStore_r, regWrData[15:0], PERIPH_WR_MASK) :
    periphStore_r;

  // Read mux, reserved upper halves read zero, unmapped reads zero
  wire logic [31:0] rdMux =
    hitCode   ? {16'h0000, codeView}   :
    hitPeriph ? {16'h0000, periphView} :
    hitCfgA   ? pcfgA_r :
    hitCfgB   ? pcfgB_r :
    hitCfgC   ? pcfgC_r : RD_IDLE;
  wire logic [31:0] regRdData_nxt = regRdStb ? rdMux : RD_IDLE;

  // Effective per-segment code cacheability, peripheral overrides
  logic [15:0] codeAllow_nxt;
  genvar g;
  generate
    for (g = 0; g < SEG_COUNT; g = g + 1) begin : gSeg
      assign codeAllow_nxt[g] = codeView[g] & ~periphView[g];
    end
  endgenerate

  // Attribute halfwords
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      codeStore_r   <= CODE_RESET;
      periphStore_r <= PERIPH_RESET;
    end else begin
      codeStore_r   <= codeStore_nxt;
      periphStore_r <= periphStore_nxt;
    end
  end

  // Program memory configuration words, lock protected
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pcfgA_r <= PCFG_RESET;
      pcfgB_r <= PCFG_RESET;
      pcfgC_r <= PCFG_RESET;
    end else begin
      if (wrOpen & hitCfgA) pcfgA_r <= regWrData;
      if (wrOpen & hitCfgB) pcfgB_r <= regWrData;
      if (wrOpen & hitCfgC) pcfgC_r <= regWrData;
    end
  end

  // Read data and refusal pulse, one cycle after the strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      regRdData_r <= RD_IDLE;
      wrRefused_r <= 1'b0;
    end else begin
      regRdData_r <= regRdData_nxt;
      wrRefused_r <= wrLocked;
    end
  end

  // Attribute outputs to fetch and cache control
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      codeCacheAllow_r <= CODE_RESET & ~PERIPH_RESET;
      uncachedSeg_r    <= PERIPH_RESET;
    end else begin
      codeCacheAllow_r <= codeAllow_nxt;
      uncachedSeg_r    <= periphView;
    end
  end

  assign progCfgA_r = pcfgA_r;
  assign progCfgB_r = pcfgB_r;
  assign progCfgC_r = pcfgC_r;

  // Maps handed to the fetch checker
  sca_attr_if attrBus ();
  assign attrBus.codeMap   = codeView;
  assign attrBus.periphMap = periphView;

  sca_fetch_check uFetch (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .attr             (attrBus.chk),
    .fetchValid       (fetchValid),
    .fetchAddr        (fetchAddr),
    .fetchDone_r      (fetchDone_r),
    .fetchCacheable_r (fetchCacheable_r),
    .fetchTrap_r      (fetchTrap_r)
  );

  // Register bank checks

  // Code map read: reserved half zero, segments F and C off
  AST_CODE_FIXED_RD: assert property (
    @(posedge clk) disable iff (sys_rst)
    regRdStb && hitCode
      |=> regRdData_r[31:16] == 16'h0000
          && !regRdData_r[SEG_F_BIT]
          && !regRdData_r[SEG_C_BIT])
    else $error("code map fixed bits wrong");

  // Segment C never code cacheable, on every read
  AST_CODE_SEG_C: assert property (
    @(posedge clk) disable iff (sys_rst)
    regRdStb && hitCode
      |=> !regRdData_r[SEG_C_BIT])
    else $error("segment C code bit set");

  // Peripheral map read: reserved half zero, segment F set
  AST_PERIPH_FIXED_RD: assert property (
    @(posedge clk) disable iff (sys_rst)
    regRdStb && hitPeriph
      |=> regRdData_r[31:16] == 16'h0000
          && regRdData_r[SEG_F_BIT])
    else $error("peripheral map fixed bits wrong");

  // Open write to the code map lands on the writable bits
  AST_CODE_WRITE: assert property (
    @(posedge clk) disable iff (sys_rst)
    regWrStb && initLockOpen && hitCode
      |=> codeView == ($past(regWrData[15:0]) & CODE_WR_MASK))
    else $error("code map write lost");

  // Open write to the peripheral map lands, bit 15 stays set
  AST_PERIPH_WRITE: assert property (
    @(posedge clk) disable iff (sys_rst)
    regWrStb && initLockOpen && hitPeriph
      |=> periphView == (($past(regWrData[15:0]) & PERIPH_WR_MASK)
                         | PERIPH_FIXED))
    else $error("peripheral map write lost");

  // Locked writes change no stored word
  AST_LOCKED_HOLD: assert property (
    @(posedge clk) disable iff (sys_rst)
    regWrStb && !initLockOpen
      |=> $stable(codeStore_r)
          && $stable(periphStore_r)
          && $stable(pcfgA_r)
          && $stable(pcfgB_r)
          && $stable(pcfgC_r))
    else $error("write landed while locked");

  // Locked write to a mapped word raises the refusal pulse
  AST_LOCKED_FLAG: assert property (
    @(posedge clk) disable iff (sys_rst)
    regWrStb && !initLockOpen && hitAny
      |=> wrRefused_r)
    else $error("refusal pulse missing");

  // Refusal pulse only follows a locked mapped write
  AST_REFUSE_CAUSE: assert property (
    @(posedge clk) disable iff (sys_rst)
    wrRefused_r
      |-> $past(regWrStb) && !$past(initLockOpen)
          && $past(hitAny))
    else $error("refusal pulse without cause");

  // Config word written then read back at once
  AST_CFG_WRITE: assert property (
    @(posedge clk) disable iff (sys_rst)
    regWrStb && initLockOpen && hitCfgB ##1 regRdStb && hitCfgB
      |=> regRdData_r == $past(regWrData, 2))
    else $error("config word readback wrong");

  // Peripheral segments never left code cacheable
  AST_OVERRIDE: assert property (
    @(posedge clk) disable iff (sys_rst)
    (codeCacheAllow_r & uncachedSeg_r) == 16'h0000
      && uncachedSeg_r[SEG_F_BIT]
      && !codeCacheAllow_r[SEG_C_BIT])
    else $error("peripheral segment left cacheable");

  // Allow output follows the code map one cycle later
  AST_ALLOW_TRACK: assert property (
    @(posedge clk) disable iff (sys_rst)
    1'b1
      |=> codeCacheAllow_r == ($past(codeView) & ~$past(periphView)))
    else $error("allow output stale");

  // Uncached output follows the peripheral map one cycle later
  AST_UNCACHED_TRACK: assert property (
    @(posedge clk) disable iff (sys_rst)
    1'b1
      |=> uncachedSeg_r == $past(periphView))
    else $error("uncached output stale");

  // Read data stands one cycle only
  AST_RD_ONE_CYCLE: assert property (
    @(posedge clk) disable iff (sys_rst)
    !regRdStb |=> regRdData_r == RD_IDLE)
    else $error("read data outside its cycle");

  // Main scenarios reached
  COV_LOCKED_WRITE: cover property (
    @(posedge clk) disable iff (sys_rst)
    wrRefused_r);
  COV_PERIPH_SET: cover property (
    @(posedge clk) disable iff (sys_rst)
    regWrStb && initLockOpen && hitPeriph && regWrData[3]);
  COV_CODE_RDBACK: cover property (
    @(posedge clk) disable iff (sys_rst)
    regWrStb && initLockOpen && hitCode ##1 regRdStb && hitCode);

endmodule : sca_attr_regs

// File: verification/sca_fetch_core_model.sv
// Core fetch side model: issues single fetches and returns answers.
// Assumes the attribute bank answers one cycle after the fetch.
`timescale 1ns/10ps
module sca_fetch_core_model (
  input  wire logic        clk,
  output logic             fetchValid,
  output logic      [31:0] fetchAddr,
  input  wire logic        fetchDone_r,
  input  wire logic        fetchCacheable_r,
  input  wire logic        fetchTrap_r
);
  // Idle bus after time zero
  initial begin
    fetchValid = 1'b0;
    fetchAddr  = 32'h0000_0000;
  end

  // One fetch, top address bits pick the segment
  task automatic fetch(input logic [3:0] seg, output logic [2:0] ans);
    @(posedge clk);
    fetchValid <= 1'b1;
    fetchAddr  <= {seg, 28'h5A5_A5A4};
    @(posedge clk);
    fetchValid <= 1'b0;
    fetchAddr  <= ~{seg, 28'h5A5_A5A4}; // Released, no stale address
    #1 ans = {fetchDone_r, fetchCacheable_r, fetchTrap_r};
  endtask : fetch
endmodule : sca_fetch_core_model

// File: verification/sca_attr_regs_tb.sv
// Testbench for the segment attribute register bank.
// Assumes a single 40 MHz clock and a core fetch model.
`timescale 1ns/10ps
module sca_attr_regs_tb import sca_pkg::*;;
  logic        clk, sys_rst, regWrStb, regRdStb, initLockOpen, refused;
  logic        wrRefused_r, fetchValid, fetchDone_r;
  logic        fetchCacheable_r, fetchTrap_r;
  logic [15:0] regAddr, codeCacheAllow_r, uncachedSeg_r;
  logic [31:0] regWrData, regRdData_r, fetchAddr;
  logic [31:0] progCfgA_r, progCfgB_r, progCfgC_r;
  int          failCount, nCompared, cycles;

  // Design and core fetch model
  sca_attr_regs DUT (.clk, .sys_rst, .regAddr, .regWrData, .regWrStb,
    .regRdStb, .regRdData_r, .wrRefused_r, .initLockOpen, .fetchValid,
    .fetchAddr, .fetchDone_r, .fetchCacheable_r, .fetchTrap_r,
    .codeCacheAllow_r, .uncachedSeg_r, .progCfgA_r, .progCfgB_r,
    .progCfgC_r);
  sca_fetch_core_model core (.clk, .fetchValid, .fetchAddr, .fetchDone_r,
    .fetchCacheable_r, .fetchTrap_r);

  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failCount++;
      stop_test();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
    nCompared++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // Register port cycles
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    regWrStb  <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk);
    regWrStb  <= 1'b0;
    regWrData <= ~d;
    #1 refused = wrRefused_r;
  endtask : wr
  task automatic rdChk(input logic [15:0] a, input logic [31:0] e);
    @(posedge clk);
    regRdStb <= 1'b1;
    regAddr  <= a;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1 check(regRdData_r, e, "read data");
  endtask : rdChk

  // Values after reset
  task automatic testReset();
    rdChk(CODE_MAP_ADDR, 32'h0000_0300);
    rdChk(PERIPH_MAP_ADDR, 32'h0000_C000);
    rdChk(PCFG_A_ADDR, 32'h0000_0000);
    rdChk(16'h8108, 32'h0000_0000);
    check({uncachedSeg_r, codeCacheAllow_r},
          32'hC000_0300, "rst map");
  endtask : testReset

  // Fixed bits, writable bits and the peripheral override
  task automatic testMaps();
    wr(CODE_MAP_ADDR, 32'hFFFF_FFFF);
    rdChk(CODE_MAP_ADDR, 32'h0000_6FFF);
    check({16'h0, codeCacheAllow_r}, 32'h0000_2FFF, "allow");
    wr(PERIPH_MAP_ADDR, 32'h0000_0000);
    rdChk(PERIPH_MAP_ADDR, 32'h0000_8000);
    wr(PERIPH_MAP_ADDR, 32'hFFFF_0101);
    rdChk(PERIPH_MAP_ADDR, 32'h0000_8101);
    // Cache upkeep after map changes is software's, none cached here
    check({uncachedSeg_r, codeCacheAllow_r},
          32'h8101_6EFE, "ovr");
  endtask : testMaps

  // Every segment fetched against code 6FFF, peripheral 8101
  task automatic testFetch();
    logic [2:0]  ans;
    logic [15:0] code, per;
    code = 16'h6FFF;
    per  = 16'h8101;
    for (int s = 0; s < SEG_COUNT; s++) begin
      core.fetch(s[3:0], ans);
      check({29'h0, ans},
            {29'h0, 1'b1, code[s] & ~per[s], per[s]}, "fetch");
    end
  endtask : testFetch

  // Closed lock refuses attribute and config writes
  task automatic testLock();
    @(posedge clk);
    initLockOpen <= 1'b0;
    wr(CODE_MAP_ADDR, 32'h0000_0000);
    check({31'h0, refused}, 32'h1, "refused");
    wr(PERIPH_MAP_ADDR, 32'h0000_0000);
    check({31'h0, refused}, 32'h1, "refused");
    wr(PCFG_B_ADDR, 32'h0000_0055);
    rdChk(CODE_MAP_ADDR, 32'h0000_6FFF);
    rdChk(PERIPH_MAP_ADDR, 32'h0000_8101);
    rdChk(PCFG_B_ADDR, 32'h0000_0000);
    @(posedge clk);
    initLockOpen <= 1'b1;
    wr(CODE_MAP_ADDR, 32'h0000_1001);
    check({31'h0, refused}, 32'h0, "accepted");
    rdChk(CODE_MAP_ADDR, 32'h0000_0001);
  endtask : testLock

  // Program memory configuration words
  task automatic testProgCfg();
    wr(PCFG_A_ADDR, 32'h1234_5678);
    wr(PCFG_B_ADDR, 32'h9ABC_DEF0);
    wr(PCFG_C_ADDR, 32'hFFFF_FFFF);
    rdChk(PCFG_A_ADDR, 32'h1234_5678);
    rdChk(PCFG_B_ADDR, 32'h9ABC_DEF0);
    rdChk(PCFG_C_ADDR, 32'hFFFF_FFFF);
    check(progCfgA_r, 32'h1234_5678, "cfg out");
    check(progCfgB_r, 32'h9ABC_DEF0, "cfg out");
    check(progCfgC_r, 32'hFFFF_FFFF, "cfg out");
  endtask : testProgCfg

  task automatic stop_test();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  // Main sequence
  initial begin
    {regWrStb, regRdStb, failCount, nCompared, cycles} = '0;
    {regAddr, regWrData} = '0;
    initLockOpen = 1'b1;
    sys_rst      = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    testReset();
    testMaps();
    testFetch();
    testLock();
    testProgCfg();
    stop_test();
  end
endmodule : sca_attr_regs_tb
